// [design/gpb_port_bank.sv]
// Purpose: seven 8-bit general-purpose ports with direction, latch and pads.
// Assumes: pins arrive asynchronously; peripherals run on sys_clk.
// Notes: pin vectors hold port p bit b at index p*8+b.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module gpb_port_bank (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [gpb_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [gpb_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [gpb_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [gpb_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [gpb_pkg::PIN_W-1:0] pinIn,
	output logic [gpb_pkg::PIN_W-1:0] pinOut,
	output logic [gpb_pkg::PIN_W-1:0] pinOe,
	output logic [gpb_pkg::PIN_W-1:0] pullupEn,
	output logic [gpb_pkg::PIN_W-1:0] driveHigh,
	output logic [6:0][1:0] inputThreshold,
	input wire logic [gpb_pkg::PIN_W-1:0] periphOutEn,
	input wire logic [gpb_pkg::PIN_W-1:0] periphOut,
	output logic subOscEnable,
	output logic mainOscEnable,
	output logic adcEnable
);
	gpb_pkg::gpb_regacc_s acc;
	gpb_pkg::gpb_regrsp_s rsp;
	logic [6:0][7:0] directionReg;
	logic [6:0][7:0] portLatchReg;
	logic [7:0] pullupSelectRegA;
	logic [7:0] pullupSelectRegB;
	logic [7:0] narrowDriveRegA;
	logic [7:0] narrowDriveRegB;
	logic [7:0] driveStrengthRegA;
	logic [7:0] driveStrengthRegB;
	logic [7:0] inputThresholdRegA;
	logic [7:0] inputThresholdRegB;
	logic [7:0] protectReg;
	logic [7:0] usageReg;
	logic [gpb_pkg::PIN_W-1:0] levelVec;
	logic [gpb_pkg::PIN_W-1:0] usableVec;
	logic [gpb_pkg::PIN_W-1:0] pullVec;
	logic [gpb_pkg::PIN_W-1:0] driveVec;
	logic [6:0][7:0] portRead;
	logic [6:0] latchWrHit;
	logic [6:0] dirWrHit;
	logic [6:0] latchRdHit;
	logic [6:0] dirRdHit;
	logic cfgWrHit;
	logic [7:0] cfgRead;
	logic cfgRdHit;
	logic directionUnlockBit;

	assign directionUnlockBit = protectReg[gpb_pkg::UNLOCK_BIT];

	// Spread group select bits over the pins
	function automatic logic [gpb_pkg::PIN_W-1:0] spreadGroups(
		input logic [7:0] regA,
		input logic [7:0] regB
	);
		logic [gpb_pkg::PIN_W-1:0] v;
		v = '0;
		for (int p = 0; p < 4; p++) begin
			v[p*8 +: 4] = {4{regA[2*p]}};
			v[p*8+4 +: 4] = {4{regA[2*p+1]}};
		end
		v[35] = regB[gpb_pkg::GRP_P4_3];
		v[36 +: 4] = {4{regB[gpb_pkg::GRP_P4_HI]}};
		v[46 +: 2] = {2{regB[gpb_pkg::GRP_P5]}};
		v[48 +: 4] = {4{regB[gpb_pkg::GRP_P6_LO]}};
		v[52 +: 4] = {4{regB[gpb_pkg::GRP_P6_HI]}};
		return v;
	endfunction

	// Bus slave front end
	gpb_axil_slave u_slave (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.acc(acc),
		.rsp(rsp)
	);

	// Pins claimed by oscillators or the converter
	always_comb begin
		usableVec = '1;
		usableVec[34] = ~usageReg[gpb_pkg::USE_ADC_BIT]; // [RQ9]
		usableVec[35] = ~usageReg[gpb_pkg::USE_SUBOSC_BIT]; // [RQ7]
		usableVec[36] = ~usageReg[gpb_pkg::USE_SUBOSC_BIT]; // [RQ7]
		usableVec[38] = ~usageReg[gpb_pkg::USE_MAINOSC_BIT]; // [RQ8]
		usableVec[39] = ~usageReg[gpb_pkg::USE_MAINOSC_BIT]; // [RQ8]
	end

	// Pull-up and drive selects per pin
	always_comb begin
		pullVec = spreadGroups(pullupSelectRegA, pullupSelectRegB); // [RQ10]
		driveVec = spreadGroups(driveStrengthRegA, driveStrengthRegB); // [RQ12]
		driveVec[8 +: 8] = narrowDriveRegA; // [RQ11]
		driveVec[16 +: 8] = narrowDriveRegB; // [RQ11]
	end

	// Threshold selection per port
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			inputThreshold[p] = inputThresholdRegA[2*p +: 2]; // [RQ13]
		end
		inputThreshold[4] = inputThresholdRegB[gpb_pkg::THR_P4_POS +: 2];
		inputThreshold[5] = inputThresholdRegB[gpb_pkg::THR_P5_POS +: 2];
		inputThreshold[6] = inputThresholdRegB[gpb_pkg::THR_P6_POS +: 2];
	end

	assign subOscEnable = usageReg[gpb_pkg::USE_SUBOSC_BIT];
	assign mainOscEnable = usageReg[gpb_pkg::USE_MAINOSC_BIT];
	assign adcEnable = usageReg[gpb_pkg::USE_ADC_BIT];

	// One cell per pin position; absent pins are inert
	for (genvar i = 0; i < gpb_pkg::PIN_W; i++) begin : g_pin
		gpb_pin_cell #(
			.IMPL(gpb_pkg::LATCH_MASK[i/8][i%8]),
			.HAS_OUT(gpb_pkg::DIR_MASK[i/8][i%8]) // [RQ6] [RQ9]
		) u_cell (
			.sys_clk(sys_clk),
			.reset_n(reset_n),
			.pinIn(pinIn[i]),
			.latch(portLatchReg[i/8][i%8]),
			.dir(directionReg[i/8][i%8]),
			.usable(usableVec[i]),
			.periphEn(periphOutEn[i]),
			.periphOut(periphOut[i]),
			.pullSel(pullVec[i]),
			.driveSel(driveVec[i]),
			.pinOut(pinOut[i]),
			.pinOe(pinOe[i]),
			.pullupEn(pullupEn[i]),
			.driveHigh(driveHigh[i]),
			.level(levelVec[i])
		);
	end

	// Port data read value: latch for outputs, pin level for inputs
	always_comb begin
		for (int p = 0; p < 7; p++) begin
			portRead[p] = ((directionReg[p] & portLatchReg[p]) // [RQ3]
				| (~directionReg[p] & levelVec[p*8 +: 8])) // [RQ2]
				& gpb_pkg::LATCH_MASK[p] & usableVec[p*8 +: 8]; // [RQ7] [RQ8]
		end
	end

	// Address decode of port registers
	always_comb begin
		for (int p = 0; p < 7; p++) begin
			latchWrHit[p] = acc.wrAddr == {2'b00, gpb_pkg::LATCH_IDX[p], 2'b00};
			dirWrHit[p] = acc.wrAddr == {2'b00, gpb_pkg::DIR_IDX[p], 2'b00};
			latchRdHit[p] = acc.rdAddr == {2'b00, gpb_pkg::LATCH_IDX[p], 2'b00};
			dirRdHit[p] = acc.rdAddr == {2'b00, gpb_pkg::DIR_IDX[p], 2'b00};
		end
	end

	// Configuration register write decode
	always_comb begin
		case (acc.wrAddr)
			gpb_pkg::PULLUP_A_ADDR, gpb_pkg::PULLUP_B_ADDR,
			gpb_pkg::NARROW_A_ADDR, gpb_pkg::NARROW_B_ADDR,
			gpb_pkg::DRIVE_A_ADDR, gpb_pkg::DRIVE_B_ADDR,
			gpb_pkg::THRESH_A_ADDR, gpb_pkg::THRESH_B_ADDR,
			gpb_pkg::PROTECT_ADDR, gpb_pkg::USAGE_ADDR: cfgWrHit = 1'b1;
			default: cfgWrHit = 1'b0;
		endcase
	end

	// Configuration register read mux
	always_comb begin
		cfgRdHit = 1'b1;
		case (acc.rdAddr)
			gpb_pkg::PULLUP_A_ADDR: cfgRead = pullupSelectRegA;
			gpb_pkg::PULLUP_B_ADDR: cfgRead = pullupSelectRegB;
			gpb_pkg::NARROW_A_ADDR: cfgRead = narrowDriveRegA;
			gpb_pkg::NARROW_B_ADDR: cfgRead = narrowDriveRegB;
			gpb_pkg::DRIVE_A_ADDR: cfgRead = driveStrengthRegA;
			gpb_pkg::DRIVE_B_ADDR: cfgRead = driveStrengthRegB;
			gpb_pkg::THRESH_A_ADDR: cfgRead = inputThresholdRegA;
			gpb_pkg::THRESH_B_ADDR: cfgRead = inputThresholdRegB;
			gpb_pkg::PROTECT_ADDR: cfgRead = protectReg;
			gpb_pkg::USAGE_ADDR: cfgRead = usageReg;
			default: begin
				cfgRead = 8'h00;
				cfgRdHit = 1'b0;
			end
		endcase
	end

	// Answer to the bus slave
	always_comb begin
		rsp.wrHit = cfgWrHit | (|latchWrHit) | (|dirWrHit);
		rsp.rdHit = cfgRdHit | (|latchRdHit) | (|dirRdHit);
		rsp.rdData = cfgRead;
		for (int p = 0; p < 7; p++) begin
			if (latchRdHit[p]) begin
				rsp.rdData = portRead[p];
			end
			if (dirRdHit[p]) begin
				rsp.rdData = directionReg[p] & gpb_pkg::DIR_MASK[p]; // [RQ14]
			end
		end
	end

	// Output latches take the written bits of implemented pins only, whatever the direction
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			portLatchReg <= '0;
		end else if (acc.wrEn) begin
			for (int p = 0; p < 7; p++) begin
				if (latchWrHit[p]) begin
					portLatchReg[p] <= acc.wrData & gpb_pkg::LATCH_MASK[p]; // [RQ4]
				end
			end
		end
	end

	// Direction bits; port 0 needs the unlock bit
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			directionReg <= '0;
		end else if (acc.wrEn) begin
			for (int p = 0; p < 7; p++) begin
				if (dirWrHit[p] && (p != 0 || directionUnlockBit)) begin // [RQ16]
					directionReg[p] <= acc.wrData & gpb_pkg::DIR_MASK[p]; // [RQ1] [RQ14]
				end
			end
		end
	end

	// Unlock bit lasts for the next write only
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			protectReg <= gpb_pkg::REG_RESET;
		end else if (acc.wrEn) begin
			if (acc.wrAddr == gpb_pkg::PROTECT_ADDR) begin
				protectReg <= acc.wrData;
			end else begin
				protectReg[gpb_pkg::UNLOCK_BIT] <= 1'b0; // [RQ16]
			end
		end
	end

	// Pad configuration registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pullupSelectRegA <= gpb_pkg::REG_RESET;
			pullupSelectRegB <= gpb_pkg::REG_RESET;
			narrowDriveRegA <= gpb_pkg::REG_RESET;
			narrowDriveRegB <= gpb_pkg::REG_RESET;
			driveStrengthRegA <= gpb_pkg::REG_RESET;
			driveStrengthRegB <= gpb_pkg::REG_RESET;
			inputThresholdRegA <= gpb_pkg::THRESH_RESET;
			inputThresholdRegB <= gpb_pkg::THRESH_RESET;
			usageReg <= gpb_pkg::REG_RESET;
		end else if (acc.wrEn) begin
			case (acc.wrAddr)
				gpb_pkg::PULLUP_A_ADDR: pullupSelectRegA <= acc.wrData;
				gpb_pkg::PULLUP_B_ADDR: pullupSelectRegB <= acc.wrData;
				gpb_pkg::NARROW_A_ADDR: narrowDriveRegA <= acc.wrData;
				gpb_pkg::NARROW_B_ADDR: narrowDriveRegB <= acc.wrData;
				gpb_pkg::DRIVE_A_ADDR: driveStrengthRegA <= acc.wrData;
				gpb_pkg::DRIVE_B_ADDR: driveStrengthRegB <= acc.wrData;
				gpb_pkg::THRESH_A_ADDR: inputThresholdRegA <= acc.wrData;
				gpb_pkg::THRESH_B_ADDR: inputThresholdRegB <= acc.wrData;
				gpb_pkg::USAGE_ADDR: usageReg <= acc.wrData;
				default: begin
				end
			endcase
		end
	end
endmodule

// [design/gpb_pkg.sv]
// Purpose: constants and carrier types of the general-purpose port bank.
// Assumes: 40 MHz sys_clk, AXI4-Lite register access, 8-bit registers.
// Notes: pins are numbered port*8+bit over a 56-bit vector.
// Summary of operation
// RQ1 - Every two-way pin has its own direction bit, 0 for input, 1 for output.
// RQ2 - Reading a port returns the synchronised pin level for input pins.
// RQ3 - Reading a port returns the output latch for output pins.
// RQ4 - Writing a port updates every latch bit whatever the direction.
// RQ5 - A pin in output mode is driven with its latch value.
// RQ6 - 47 two-way pins: P0-P3, P4 bits 3-7, P5 bits 6-7 and P6.
// RQ7 - P4 bits 3, 4 are general pins only while the sub oscillator is unused.
// RQ8 - P4 bits 6, 7 are general pins only while the main oscillator is unused.
// RQ9 - P4 bit 2 is input only, and usable only while the converter is unused.
// RQ10 - Pull-ups go by 4-bit groups, per bit for P4 bit 3, in a pair for P5.
// RQ11 - Ports 1 and 2 choose low or high drive strength per pin.
// RQ12 - Ports 0, 3, 6, usable P4 and P5 pins choose drive strength by group.
// RQ13 - Each port selects one of three input thresholds as a whole group.
// RQ14 - Direction bits P4 0-2, P5 0-2 and P5 5 are absent; P5 3-4 reserved.
// RQ15 - A peripheral output drives its pin whatever the direction bit holds.
// RQ16 - Software writes P0 direction right after it sets the unlock bit.
// RQ17 - Pull-up selection has no effect on pins in output mode.
package gpb_pkg;
	localparam int PIN_W = 56;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int CLK_HZ = 40000000;
	// Printed register indices; the byte address is four times the index
	localparam logic [6:0][7:0] LATCH_IDX = {8'hec, 8'he9, 8'he8, 8'he5,
		8'he4, 8'he1, 8'he0};
	localparam logic [6:0][7:0] DIR_IDX = {8'hee, 8'heb, 8'hea, 8'he7,
		8'he6, 8'he3, 8'he2};
	// Implemented direction bits and readable pin bits per port
	localparam logic [6:0][7:0] DIR_MASK = {8'hff, 8'hc0, 8'hf8, 8'hff,
		8'hff, 8'hff, 8'hff};
	localparam logic [6:0][7:0] LATCH_MASK = {8'hff, 8'hc0, 8'hfc, 8'hff,
		8'hff, 8'hff, 8'hff};
	// Configuration register byte addresses
	localparam logic [ADDR_W-1:0] PULLUP_A_ADDR = 12'h400;
	localparam logic [ADDR_W-1:0] PULLUP_B_ADDR = 12'h404;
	localparam logic [ADDR_W-1:0] NARROW_A_ADDR = 12'h408;
	localparam logic [ADDR_W-1:0] NARROW_B_ADDR = 12'h40c;
	localparam logic [ADDR_W-1:0] DRIVE_A_ADDR = 12'h410;
	localparam logic [ADDR_W-1:0] DRIVE_B_ADDR = 12'h414;
	localparam logic [ADDR_W-1:0] THRESH_A_ADDR = 12'h418;
	localparam logic [ADDR_W-1:0] THRESH_B_ADDR = 12'h41c;
	localparam logic [ADDR_W-1:0] PROTECT_ADDR = 12'h420;
	localparam logic [ADDR_W-1:0] USAGE_ADDR = 12'h424;
	// Field positions
	localparam int UNLOCK_BIT = 2;
	localparam int USE_SUBOSC_BIT = 0;
	localparam int USE_MAINOSC_BIT = 1;
	localparam int USE_ADC_BIT = 2;
	localparam int GRP_P4_3 = 0;
	localparam int GRP_P4_HI = 1;
	localparam int GRP_P5 = 2;
	localparam int GRP_P6_LO = 4;
	localparam int GRP_P6_HI = 5;
	localparam int THR_P4_POS = 0;
	localparam int THR_P5_POS = 2;
	localparam int THR_P6_POS = 4;
	// Threshold codes
	localparam logic [1:0] THR_035 = 2'h0;
	localparam logic [1:0] THR_050 = 2'h1;
	localparam logic [1:0] THR_070 = 2'h2;
	// Reset values and bus response codes
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] THRESH_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Write command and read address from the bus slave
	typedef struct packed {
		logic wrEn;
		logic [ADDR_W-1:0] wrAddr;
		logic [7:0] wrData;
		logic [ADDR_W-1:0] rdAddr;
	} gpb_regacc_s;

	// Decode answer from the register file
	typedef struct packed {
		logic wrHit;
		logic rdHit;
		logic [7:0] rdData;
	} gpb_regrsp_s;
endpackage

// [design/gpb_pin_cell.sv]
// Purpose: one port pin: input synchroniser, output drive and pad controls.
// Assumes: pinIn is asynchronous to sys_clk.
// Notes: pad controls are registered, one cycle after their cause.
`timescale 1ns/100ps
module gpb_pin_cell #(
	parameter bit IMPL = 1'b1,
	parameter bit HAS_OUT = 1'b1
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic pinIn,
	input wire logic latch,
	input wire logic dir,
	input wire logic usable,
	input wire logic periphEn,
	input wire logic periphOut,
	input wire logic pullSel,
	input wire logic driveSel,
	output logic pinOut,
	output logic pinOe,
	output logic pullupEn,
	output logic driveHigh,
	output logic level
);
	logic syncA;
	logic syncB;
	logic drive;

	// Two-stage synchroniser of the pad level
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
		end else begin
			syncA <= pinIn;
			syncB <= syncA;
		end
	end

	assign level = syncB & IMPL & usable; // [RQ2] [RQ9]
	// Peripheral output wins over the direction bit
	assign drive = HAS_OUT & usable & (periphEn | dir); // [RQ5] [RQ15]

	// Pad controls
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pinOut <= 1'b0;
			pinOe <= 1'b0;
			pullupEn <= 1'b0;
			driveHigh <= 1'b0;
		end else begin
			pinOut <= periphEn ? periphOut : latch; // [RQ5] [RQ15]
			pinOe <= drive;
			pullupEn <= HAS_OUT & usable & ~drive & pullSel; // [RQ17]
			driveHigh <= HAS_OUT & usable & driveSel;
		end
	end
endmodule

// [design/gpb_axil_slave.sv]
// Purpose: AXI4-Lite slave front end of the port bank registers.
// Assumes: one write and one read outstanding at most.
// Notes: write acts the cycle after both address and data are held.
`timescale 1ns/100ps
module gpb_axil_slave (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [gpb_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [gpb_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [gpb_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [gpb_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output gpb_pkg::gpb_regacc_s acc,
	input wire gpb_pkg::gpb_regrsp_s rsp
);
	logic awHeld;
	logic wHeld;
	logic [gpb_pkg::ADDR_W-1:0] awAddr;
	logic [7:0] wByte;
	logic wLane;
	logic doWrite;

	assign awready = ~awHeld & ~bvalid;
	assign wready = ~wHeld & ~bvalid;
	assign arready = ~rvalid;
	assign doWrite = awHeld & wHeld & ~bvalid;

	// Register file command
	always_comb begin
		acc.wrEn = doWrite & wLane;
		acc.wrAddr = awAddr;
		acc.wrData = wByte;
		acc.rdAddr = araddr;
	end

	// Write address and data capture, either order
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wByte <= 8'h00;
			wLane <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				awHeld <= 1'b1;
				awAddr <= awaddr;
			end else if (doWrite) begin
				awHeld <= 1'b0;
			end
			if (wvalid && wready) begin
				wHeld <= 1'b1;
				wByte <= wdata[7:0];
				wLane <= wstrb[0];
			end else if (doWrite) begin
				wHeld <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			bvalid <= 1'b0;
			bresp <= gpb_pkg::RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp <= rsp.wrHit ? gpb_pkg::RESP_OKAY : gpb_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Read data, taken in the address handshake cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= gpb_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= {24'h000000, rsp.rdData};
			rresp <= rsp.rdHit ? gpb_pkg::RESP_OKAY : gpb_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule

// [verification/gpb_pin_model.sv]
// Purpose: external devices and wiring on the port pins.
// Assumes: one pad driver per pin at a time.
// Notes: an undriven pin without pull-up toggles every cycle.
`timescale 1ns/100ps
module gpb_pin_model (
	input wire logic sys_clk,
	input wire logic [gpb_pkg::PIN_W-1:0] pinOut,
	input wire logic [gpb_pkg::PIN_W-1:0] pinOe,
	input wire logic [gpb_pkg::PIN_W-1:0] pullupEn,
	input wire logic [gpb_pkg::PIN_W-1:0] extEn,
	input wire logic [gpb_pkg::PIN_W-1:0] extVal,
	output logic [gpb_pkg::PIN_W-1:0] pinIn
);
	logic [gpb_pkg::PIN_W-1:0] floatPat = '0;

	// Floating lines wander so no stale level reads back
	always @(posedge sys_clk) begin
		floatPat <= ~floatPat;
	end

	// Pad drive wins, then the device, then pull-up or float
	assign pinIn = (pinOe & pinOut)
		| (~pinOe & extEn & extVal)
		| (~pinOe & ~extEn & (pullupEn | floatPat));
endmodule

// [verification/gpb_port_bank_chk.sv]
// Purpose: bus handshake and pad checks on the port bank top.
// Assumes: one sys_clk domain, synchronous active low reset.
// Notes: attached by bind below the module.
`timescale 1ns/100ps
module gpb_port_bank_chk (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [gpb_pkg::DATA_W-1:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [gpb_pkg::PIN_W-1:0] pinOut,
	input wire logic [gpb_pkg::PIN_W-1:0] pinOe,
	input wire logic [gpb_pkg::PIN_W-1:0] pullupEn,
	input wire logic [gpb_pkg::PIN_W-1:0] driveHigh,
	input wire logic [gpb_pkg::PIN_W-1:0] periphOutEn,
	input wire logic [gpb_pkg::PIN_W-1:0] periphOut
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_wrLat;
		awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
	endproperty
	a_wrLat: assert property (p_wrLat)
		else $error("write answer not two cycles after request");
	property p_bHold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bHold: assert property (p_bHold)
		else $error("write answer dropped early");
	property p_rdLat;
		arvalid && arready |=> rvalid;
	endproperty
	a_rdLat: assert property (p_rdLat)
		else $error("read answer late");
	property p_rHold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_rHold: assert property (p_rHold)
		else $error("read data changed while held");
	property p_rdHigh;
		rvalid |-> rdata[31:8] == 24'h0;
	endproperty
	a_rdHigh: assert property (p_rdHigh)
		else $error("read data upper bits set");
	property p_noDrv;
		pinOe[34:32] == 3'h0 && pinOe[45:40] == 6'h0;
	endproperty
	a_noDrv: assert property (p_noDrv)
		else $error("absent pin driven");
	property p_noPad;
		(pullupEn[33:32] | driveHigh[33:32]) == 2'h0
			&& (pullupEn[45:40] | driveHigh[45:40]) == 6'h0;
	endproperty
	a_noPad: assert property (p_noPad)
		else $error("absent pin pad control set");
	property p_pullOff;
		(pullupEn & pinOe) == 56'h0;
	endproperty
	a_pullOff: assert property (p_pullOff)
		else $error("pull-up on driven pin");
	property p_periph;
		periphOutEn[13] |=> pinOe[13] && pinOut[13] == $past(periphOut[13]);
	endproperty
	a_periph: assert property (p_periph)
		else $error("peripheral output not on pin");
endmodule

bind gpb_port_bank gpb_port_bank_chk chk (.sys_clk, .reset_n, .awvalid,
	.awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid,
	.arready, .rdata, .rvalid, .rready, .pinOut, .pinOe, .pullupEn,
	.driveHigh, .periphOutEn, .periphOut);

// [verification/test_gpb_port_bank.sv]
// Purpose: register and pin tests of the port bank.
// Assumes: 40 MHz sys_clk, bus tasks start at a rising edge.
// Notes: pins settle a few cycles before each look.
`timescale 1ns/100ps
module test_gpb_port_bank;
	localparam logic [1:0] OK = gpb_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = gpb_pkg::RESP_SLVERR;
	logic sys_clk, reset_n, subOscEnable, mainOscEnable, adcEnable;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [55:0] pinIn, pinOut, pinOe, pullupEn, driveHigh;
	logic [55:0] periphOutEn, periphOut, extEn, extVal;
	logic [6:0][1:0] inputThreshold;
	logic [2:0][1:0] thr;
	logic [7:0] d, e;
	int failures, compares, cycles;

	gpb_port_bank dut (.sys_clk, .reset_n, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.pinIn, .pinOut, .pinOe, .pullupEn, .driveHigh, .inputThreshold,
		.periphOutEn, .periphOut, .subOscEnable, .mainOscEnable,
		.adcEnable);
	gpb_pin_model far (.sys_clk, .pinOut, .pinOe, .pullupEn, .extEn,
		.extVal, .pinIn);

	// Clock generator
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (failures == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [63:0] x,
		input logic [63:0] g);
		compares++;
		if (g !== x) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic pause(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	function automatic logic [11:0] la(input int p);
		return {2'h0, gpb_pkg::LATCH_IDX[p], 2'h0};
	endfunction

	function automatic logic [11:0] da(input int p);
		return {2'h0, gpb_pkg::DIR_IDX[p], 2'h0};
	endfunction

	// Write one byte, both channels offered together
	task automatic wr(input logic [11:0] a, input logic [7:0] v,
		input logic [1:0] xr);
		logic ah, wh, ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge sys_clk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			@(posedge sys_clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			ad = ad | ah;
			wd = wd | wh;
		end while (!(ad && wd));
		do @(negedge sys_clk); while (bvalid !== 1'b1);
		@(posedge sys_clk);
		bready <= 1'b1;
		@(negedge sys_clk);
		chk("bresp", {62'h0, xr}, {62'h0, bresp});
		@(posedge sys_clk);
		bready <= 1'b0;
	endtask

	// Read one byte with a stalled answer
	task automatic rd(input logic [11:0] a, input logic [7:0] x,
		input logic [1:0] xr);
		logic ah;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge sys_clk);
			ah = arready;
			@(posedge sys_clk);
		end while (ah !== 1'b1);
		arvalid <= 1'b0;
		do @(negedge sys_clk); while (rvalid !== 1'b1);
		@(posedge sys_clk);
		rready <= 1'b1;
		@(negedge sys_clk);
		chk("rdata", {56'h0, x}, {32'h0, rdata});
		chk("rresp", {62'h0, xr}, {62'h0, rresp});
		@(posedge sys_clk);
		rready <= 1'b0;
	endtask

	// Main sequence
	initial begin
		cycles = 0;
		failures = 0;
		compares = 0;
		thr = {gpb_pkg::THR_070, gpb_pkg::THR_050, gpb_pkg::THR_035};
		{reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata} = 56'h0;
		wstrb = 4'h1;
		{periphOutEn, periphOut, extVal} = 168'h0;
		extEn = '1;
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		pause(1);
		chk("pinOe", 64'h0, {8'h0, pinOe});
		// Latch, direction and pin level on every port
		for (int p = 0; p < 7; p++) begin
			e = gpb_pkg::LATCH_MASK[p];
			d = 8'hd9 & gpb_pkg::DIR_MASK[p];
			rd(da(p), 8'h00, OK);
			extVal[p*8+:8] <= 8'ha5;
			wr(la(p), 8'h3c, OK);
			pause(3);
			rd(la(p), 8'ha5 & e, OK);
			if (p == 0) wr(gpb_pkg::PROTECT_ADDR, 8'h04, OK);
			wr(da(p), 8'hd9, OK);
			extVal[p*8+:8] <= 8'h5a;
			pause(3);
			chk("pinOe", {56'h0, d}, {56'h0, pinOe[p*8+:8]});
			chk("pinOut", {56'h0, 8'h3c & d},
				{56'h0, pinOut[p*8+:8] & d});
			rd(da(p), d, OK);
			rd(la(p), ((8'h3c & d) | (8'h5a & ~d)) & e, OK);
		end
		// Unlock only covers the very next write
		wr(gpb_pkg::PROTECT_ADDR, 8'h04, OK);
		wr(la(1), 8'h3c, OK);
		wr(da(0), 8'hff, OK);
		rd(da(0), 8'hd9, OK);
		wr(12'h7f0, 8'hff, ERR);
		rd(12'h7f0, 8'h00, ERR);
		// Oscillators and converter claim their pins
		wr(gpb_pkg::USAGE_ADDR, 8'h07, OK);
		extVal[39:32] <= 8'hff;
		pause(3);
		chk("usage", 64'h7,
			{61'h0, subOscEnable, mainOscEnable, adcEnable});
		chk("pinOe", 64'h0, {56'h0, pinOe[39:32]});
		rd(la(4), 8'h20, OK);
		wr(gpb_pkg::USAGE_ADDR, 8'h00, OK);
		// Pull-up groups, only on input pins
		wr(gpb_pkg::PULLUP_A_ADDR, 8'h08, OK);
		pause(2);
		chk("pullupEn", 64'h20, {56'h0, pullupEn[15:8]});
		wr(gpb_pkg::PULLUP_A_ADDR, 8'h0c, OK);
		extEn[15:8] <= 8'h00;
		pause(4);
		chk("pullupEn", 64'h26, {56'h0, pullupEn[15:8]});
		rd(la(1), 8'h3e, OK);
		// Write with lane 0 off leaves the latch alone
		wstrb <= 4'h0;
		wr(la(1), 8'h00, OK);
		wstrb <= 4'h1;
		rd(la(1), 8'h3e, OK);
		periphOutEn[13] <= 1'b1;
		periphOut[13] <= 1'b1;
		pause(2);
		chk("periph", 64'h5,
			{61'h0, pinOe[13], pullupEn[13], pinOut[13]});
		// Second pull-up register: port 6 groups and the port 5 pair
		wr(gpb_pkg::PULLUP_B_ADDR, 8'h34, OK);
		pause(2);
		chk("pullupEn", 64'h2600, {48'h0, pullupEn[55:40]});
		// Drive strength per pin and per group
		wr(gpb_pkg::NARROW_A_ADDR, 8'h81, OK);
		wr(gpb_pkg::DRIVE_A_ADDR, 8'h0d, OK);
		wr(gpb_pkg::DRIVE_B_ADDR, 8'h31, OK);
		pause(2);
		chk("driveHigh", 64'h810f, {48'h0, driveHigh[15:0]});
		chk("driveHigh", 64'hff08,
			{48'h0, driveHigh[55:48], driveHigh[39:32]});
		// Every threshold code on every port
		for (int k = 0; k < 3; k++) begin
			wr(gpb_pkg::THRESH_A_ADDR, {4{thr[k]}}, OK);
			wr(gpb_pkg::THRESH_B_ADDR, {2'h0, {3{thr[k]}}}, OK);
			pause(1);
			chk("threshold", {50'h0, {7{thr[k]}}},
				{50'h0, inputThreshold});
		end
		give_verdict();
	end
endmodule
